// file: rtl/csr_pkg.sv
// Constants for the codec status and input-control register group
package csr_pkg;
   // ****************************************************************
   // Bus geometry
   // ****************************************************************
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   // ****************************************************************
   // Register addresses
   // ****************************************************************
   localparam logic [4:0] ADDR_STATUS = 5'h00;
   localparam logic [4:0] ADDR_FLAGS = 5'h01;
   localparam logic [4:0] ADDR_INPUT = 5'h02;
   localparam logic [4:0] ADDR_ENABLES = 5'h1B;
   localparam logic [4:0] ADDR_FUNDAMENTAL = 5'h1C;
   // Window of addresses still writable in converter power-down
   localparam logic [4:0] ADDR_PD_LO = 5'h10;
   localparam logic [4:0] ADDR_PD_HI = 5'h18;
   localparam logic [4:0] ADDR_SERIAL = 5'h1A;
   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int ST_SETTLE_BIT = 15;
   localparam int ST_PD_BIT = 14;
   localparam int FL_SU_B_BIT = 9;
   localparam int FL_SU_A_BIT = 8;
   localparam int FL_OVR_LSB = 2;
   localparam int FL_OVL_LSB = 0;
   localparam int IN_LSS_LSB = 13;
   localparam int IN_LMB_BIT = 12;
   localparam int IN_LIG_LSB = 8;
   localparam int IN_RSS_LSB = 5;
   localparam int IN_RMB_BIT = 4;
   localparam int IN_RIG_LSB = 0;
   localparam int EN_DAC_A_BIT = 0;
   localparam int EN_DAC_B_BIT = 1;
   localparam int EN_ADC_L_BIT = 2;
   localparam int EN_ADC_R_BIT = 3;
   localparam int FN_PD_REQ_BIT = 15;
   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [15:0] FLAGS_RST = 16'h0000;
   localparam logic [15:0] INPUT_RST = 16'h0000;
   localparam logic [3:0] ENABLES_RST = 4'h0;
   localparam logic PD_REQ_RST = 1'b1;
   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_NS = 100;
   localparam int SETTLE_US = 400;
   localparam int SETTLE_CYC = (SETTLE_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int PD_SEQ_CYC = 16;
   localparam int PD_TRANS_CYC = 8;
   // Gain steps in half-decibel units
   localparam logic [5:0] BOOST_HALF_DB = 6'h28;
   localparam logic [1:0] GAIN_STEP_HALF_DB = 2'h3;
endpackage

// file: rtl/csr_regs.sv
// Status, channel flag and input control registers of the codec
//
// Operation
// - Settle flag high until clocks stabilize
// - Settle flag blocks writes, slave reads allowed
// - Reset or finished power-down sets settle flag
// - Power-down flag high while down or transitioning
// - Clock generators and serial port stay alive unless the pin is low
// - Pin low or request bit enters power-down
// - In power-down only 16-24,26,28 writable
// - Power-down flag set right after reset
// - Status shows default, refuses writes, pins low
// - Any flag register access clears it
// - Empty DAC buffer sets underrun, zero fill
// - Underrun cleared by any flag access or DAC disable
// - Sticky 2-bit ADC peak record per channel
// - Peak codes 00,01,10,11 by level band
// - Flags cleared in reset and power-down
// - Input control field layout left/right
// - Source select codes choose ADC input
// - Mic boost adds 20 dB when set
// - Status low nibble holds revision code
// - Input gain steps 1.5 dB per code
//
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
module csr_regs #(
   parameter logic [3:0] REVISION = 4'hA, // Arbitrary value
   parameter int SETTLE_CYCLES = csr_pkg::SETTLE_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic powerdown_pin_n_i,
   input wire logic bus_role_select_i,
   input wire logic [4:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   input wire logic dac_a_empty_i,
   input wire logic dac_b_empty_i,
   input wire logic adc_left_valid_i,
   input wire logic [1:0] adc_left_level_i,
   input wire logic adc_right_valid_i,
   input wire logic [1:0] adc_right_level_i,
   output logic clock_settle_o,
   output logic converter_powerdown_flag_o,
   output logic dac_a_zero_fill_o,
   output logic dac_b_zero_fill_o,
   output logic [2:0] left_source_select_o,
   output logic [2:0] right_source_select_o,
   output logic left_mic_boost_o,
   output logic right_mic_boost_o,
   output logic [3:0] left_input_gain_o,
   output logic [3:0] right_input_gain_o,
   output logic [6:0] left_gain_half_db_o,
   output logic [6:0] right_gain_half_db_o,
   output logic [3:0] channel_enables_o
);
   // ****************************************************************
   // Functions
   // ****************************************************************
   // Writable while converters are down
   function automatic logic pd_writable(input logic [4:0] a);
      pd_writable = (a >= csr_pkg::ADDR_PD_LO && a <= csr_pkg::ADDR_PD_HI) ||
                    a == csr_pkg::ADDR_SERIAL || a == csr_pkg::ADDR_FUNDAMENTAL;
   endfunction
   // Total input gain in half-dB: boost plus 1.5 dB steps, seven bits for full scale
   function automatic logic [6:0] gain_half_db(input logic boost, input logic [3:0] g);
      gain_half_db = (boost ? 7'(csr_pkg::BOOST_HALF_DB) : 7'h00) +
                     7'(g) * 7'(csr_pkg::GAIN_STEP_HALF_DB);
   endfunction
   // Sticky maximum, restarted on clear
   function automatic logic [1:0] peak_next(input logic clr, input logic en,
         input logic v, input logic [1:0] lvl, input logic [1:0] cur);
      logic [1:0] base;
      base = (clr || !en) ? 2'h0 : cur;
      peak_next = (en && v && lvl > base) ? lvl : base;
   endfunction

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic pin_meta; // First stage, read only by pin_n
   logic pin_n; // Synchronised power-down pin
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pin_meta <= 1'b1;
         pin_n <= 1'b1;
      end else begin
         pin_meta <= powerdown_pin_n_i;
         pin_n <= pin_meta;
      end
   end
   logic role_meta; // First stage of bus role
   logic slave_role; // Synchronised bus role, high for slave
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         role_meta <= 1'b1;
         slave_role <= 1'b1;
      end else begin
         role_meta <= bus_role_select_i;
         slave_role <= role_meta;
      end
   end

   // ****************************************************************
   // Clock settle sequencer (clock generators power down only on pin low)
   // ****************************************************************
   typedef enum logic [3:0] {
      CSR_SETTLE = 4'b0001,
      CSR_RUN = 4'b0010,
      CSR_PDSEQ = 4'b0100,
      CSR_OFF = 4'b1000
   } csr_clk_e;
   csr_clk_e clk_state; // Clock sequencer state
   csr_clk_e next_clk_state;
   logic [15:0] seq_cnt; // Settle and power-down counter
   logic [15:0] next_seq_cnt;
   always_comb begin
      next_clk_state = clk_state;
      next_seq_cnt = seq_cnt;
      unique case (clk_state)
         // Wait for clocks after reset or pin release
         CSR_SETTLE: begin
            if (!pin_n) begin
               next_clk_state = CSR_PDSEQ;
               next_seq_cnt = 16'h0000;
            end else if (seq_cnt == 16'(SETTLE_CYCLES - 1)) begin
               next_clk_state = CSR_RUN;
            end else begin
               next_seq_cnt = seq_cnt + 16'h0001;
            end
         end
         // Normal running, pin low starts power-down
         CSR_RUN: begin
            if (!pin_n) begin
               next_clk_state = CSR_PDSEQ;
               next_seq_cnt = 16'h0000;
            end
         end
         // Power-down sequence, then flag set
         CSR_PDSEQ: begin
            if (seq_cnt == 16'(csr_pkg::PD_SEQ_CYC - 1)) begin
               next_clk_state = CSR_OFF;
            end else begin
               next_seq_cnt = seq_cnt + 16'h0001;
            end
         end
         // Held down until the pin is released
         CSR_OFF: begin
            if (pin_n) begin
               next_clk_state = CSR_SETTLE;
               next_seq_cnt = 16'h0000;
            end
         end
         default: begin
            next_clk_state = CSR_SETTLE;
            next_seq_cnt = 16'h0000;
         end
      endcase
   end
   // Reset lands in settle
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         clk_state <= CSR_SETTLE;
         seq_cnt <= 16'h0000;
      end else begin
         clk_state <= next_clk_state;
         seq_cnt <= next_seq_cnt;
      end
   end
   wire settle = clk_state == CSR_SETTLE || clk_state == CSR_OFF;

   // ****************************************************************
   // Converter power-down
   // ****************************************************************
   logic pd_req_bit; // Software power-down request
   logic [3:0] enables; // DAC and ADC channel enables
   wire pd_want = !pin_n || pd_req_bit;
   logic pd_want_q; // Last request level
   logic [3:0] trans_cnt; // Enter or exit transition time
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pd_want_q <= 1'b1;
         trans_cnt <= 4'h0;
      end else begin
         pd_want_q <= pd_want;
         if (pd_want != pd_want_q) begin
            trans_cnt <= 4'(csr_pkg::PD_TRANS_CYC);
         end else if (trans_cnt != 4'h0) begin
            trans_cnt <= trans_cnt - 4'h1;
         end
      end
   end
   // Old level covers the cycle before the transition counter loads
   wire pd_flag = pd_want || pd_want_q || trans_cnt != 4'h0;

   // ****************************************************************
   // Access decode
   // ****************************************************************
   wire wr_ok = wr_i && !settle && (!pd_flag || pd_writable(addr_i));
   wire rd_ok = rd_i && (!settle || slave_role);
   wire fl_access = (wr_i || rd_i) && addr_i == csr_pkg::ADDR_FLAGS;
   wire wr_input = wr_ok && addr_i == csr_pkg::ADDR_INPUT;
   wire wr_enables = wr_ok && addr_i == csr_pkg::ADDR_ENABLES;
   wire wr_fund = wr_ok && addr_i == csr_pkg::ADDR_FUNDAMENTAL;

   // ****************************************************************
   // Control registers
   // ****************************************************************
   logic [15:0] input_ctrl; // Source, boost and gain fields
   // Conversion registers clear while converters are down
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         input_ctrl <= csr_pkg::INPUT_RST;
         enables <= csr_pkg::ENABLES_RST;
         pd_req_bit <= csr_pkg::PD_REQ_RST;
      end else begin
         if (pd_flag) begin
            input_ctrl <= csr_pkg::INPUT_RST;
            enables <= csr_pkg::ENABLES_RST;
         end else begin
            if (wr_input) input_ctrl <= wdata_i;
            if (wr_enables) enables <= wdata_i[3:0];
         end
         if (!pin_n) begin
            pd_req_bit <= csr_pkg::PD_REQ_RST;
         end else if (wr_fund) begin
            pd_req_bit <= wdata_i[csr_pkg::FN_PD_REQ_BIT];
         end
      end
   end

   // ****************************************************************
   // Channel flags
   // ****************************************************************
   logic su_a; // DAC pair A underrun
   logic su_b; // DAC pair B underrun
   logic [1:0] peak_l; // Left ADC peak record
   logic [1:0] peak_r; // Right ADC peak record
   wire en_da = enables[csr_pkg::EN_DAC_A_BIT] && !pd_flag;
   wire en_db = enables[csr_pkg::EN_DAC_B_BIT] && !pd_flag;
   wire en_al = enables[csr_pkg::EN_ADC_L_BIT] && !pd_flag;
   wire en_ar = enables[csr_pkg::EN_ADC_R_BIT] && !pd_flag;
   // Events win over a clear in the same cycle
   wire next_su_a = en_da && (dac_a_empty_i || (su_a && !fl_access));
   wire next_su_b = en_db && (dac_b_empty_i || (su_b && !fl_access));
   wire [1:0] next_peak_l = peak_next(fl_access, en_al, adc_left_valid_i,
                                      adc_left_level_i, peak_l);
   wire [1:0] next_peak_r = peak_next(fl_access, en_ar, adc_right_valid_i,
                                      adc_right_level_i, peak_r);
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         su_a <= 1'b0;
         su_b <= 1'b0;
         peak_l <= 2'h0;
         peak_r <= 2'h0;
      end else begin
         su_a <= next_su_a;
         su_b <= next_su_b;
         peak_l <= next_peak_l;
         peak_r <= next_peak_r;
      end
   end
   wire [15:0] flags_word = {6'h00, su_b, su_a, 4'h0, peak_r, peak_l};

   // ****************************************************************
   // Read mux, unmapped and reserved read as zero
   // ****************************************************************
   wire [15:0] status_word = {settle || !pin_n, pd_flag, 10'h000, REVISION};
   logic [15:0] next_rdata;
   always_comb begin
      next_rdata = 16'h0000;
      if (rd_ok) begin
         unique case (addr_i)
            csr_pkg::ADDR_STATUS: next_rdata = status_word;
            csr_pkg::ADDR_FLAGS: next_rdata = flags_word;
            csr_pkg::ADDR_INPUT: next_rdata = input_ctrl;
            csr_pkg::ADDR_ENABLES: next_rdata = {12'h000, enables};
            csr_pkg::ADDR_FUNDAMENTAL: next_rdata = {pd_req_bit, 15'h0000};
            default: next_rdata = 16'h0000;
         endcase
      end
   end

   // ****************************************************************
   // Output registers
   // ****************************************************************
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= 16'h0000;
         clock_settle_o <= 1'b1;
         converter_powerdown_flag_o <= 1'b1;
         dac_a_zero_fill_o <= 1'b0;
         dac_b_zero_fill_o <= 1'b0;
         left_source_select_o <= 3'h0;
         right_source_select_o <= 3'h0;
         left_mic_boost_o <= 1'b0;
         right_mic_boost_o <= 1'b0;
         left_input_gain_o <= 4'h0;
         right_input_gain_o <= 4'h0;
         left_gain_half_db_o <= 7'h00;
         right_gain_half_db_o <= 7'h00;
         channel_enables_o <= 4'h0;
      end else begin
         rdata_o <= next_rdata;
         clock_settle_o <= settle;
         converter_powerdown_flag_o <= pd_flag;
         dac_a_zero_fill_o <= dac_a_empty_i;
         dac_b_zero_fill_o <= dac_b_empty_i;
         left_source_select_o <= input_ctrl[csr_pkg::IN_LSS_LSB +: 3];
         right_source_select_o <= input_ctrl[csr_pkg::IN_RSS_LSB +: 3];
         left_mic_boost_o <= input_ctrl[csr_pkg::IN_LMB_BIT];
         right_mic_boost_o <= input_ctrl[csr_pkg::IN_RMB_BIT];
         left_input_gain_o <= input_ctrl[csr_pkg::IN_LIG_LSB +: 4];
         right_input_gain_o <= input_ctrl[csr_pkg::IN_RIG_LSB +: 4];
         left_gain_half_db_o <= gain_half_db(input_ctrl[csr_pkg::IN_LMB_BIT],
            input_ctrl[csr_pkg::IN_LIG_LSB +: 4]);
         right_gain_half_db_o <= gain_half_db(input_ctrl[csr_pkg::IN_RMB_BIT],
            input_ctrl[csr_pkg::IN_RIG_LSB +: 4]);
         channel_enables_o <= enables;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_settle_blocks_write: assert property (
      settle && wr_i |=> $stable(input_ctrl) && $stable(pd_req_bit))
      else $error("write taken while clocks settle");
   a_pd_blocks_enables: assert property (
      pd_flag && wr_i && addr_i == csr_pkg::ADDR_ENABLES |=> enables == 4'h0)
      else $error("enable register written in power-down");
   a_pd_follows_req: assert property (
      pd_want |=> converter_powerdown_flag_o)
      else $error("power-down flag low while requested");
   a_pd_exit_hold: assert property (
      pd_want_q && !pd_want |=> converter_powerdown_flag_o)
      else $error("power-down flag dropped while leaving");
   a_flags_access_clear: assert property (
      fl_access && !dac_a_empty_i && !dac_b_empty_i && !adc_left_valid_i
      && !adc_right_valid_i |=> flags_word == 16'h0000)
      else $error("flags not cleared by access");
   a_flags_pd_clear: assert property (
      pd_flag |=> flags_word == 16'h0000)
      else $error("flags held in power-down");
   a_underrun_set: assert property (
      dac_a_empty_i && en_da |=> su_a && dac_a_zero_fill_o)
      else $error("underrun not recorded");
   a_read_old_flags: assert property (
      rd_ok && addr_i == csr_pkg::ADDR_FLAGS |=> rdata_o == $past(flags_word))
      else $error("flag read lost old value");
   a_status_pin_low: assert property (
      !pin_n && rd_ok && addr_i == csr_pkg::ADDR_STATUS
      |=> rdata_o[csr_pkg::ST_SETTLE_BIT] && rdata_o[csr_pkg::ST_PD_BIT])
      else $error("status not at default with pin low");
   a_peak_sticky: assert property (
      !fl_access && en_al ##1 en_al |-> peak_l >= $past(peak_l))
      else $error("peak record decreased");
   a_settle_released: assert property (
      clk_state == CSR_SETTLE && seq_cnt == 16'(SETTLE_CYCLES - 1) && pin_n
      |=> !settle ##1 !clock_settle_o)
      else $error("settle flag not released");
   c_settle_done: cover property (settle ##1 !settle);
   c_flag_read: cover property (rd_ok && addr_i == csr_pkg::ADDR_FLAGS && su_a);
   c_pd_exit: cover property (pd_flag ##1 !pd_flag);
   c_peak_over: cover property (peak_r == 2'h3);
endmodule

// file: testbench/csr_host_model.sv
// Host-side bus master model for the codec register group
`timescale 1ns/100ps
module csr_host_model (
   input wire logic clk_i,
   input wire logic [15:0] rdata_i,
   output logic [4:0] addr_o,
   output logic [15:0] wdata_o,
   output logic wr_o,
   output logic rd_o
);
   // ****************************************************************
   // Idle bus at time zero
   // ****************************************************************
   initial begin
      addr_o = 5'h1F;
      wdata_o = 16'hA5A5;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end
   // ****************************************************************
   // Access tasks
   // ****************************************************************
   // One-cycle write; reserved bits go out as zero by caller's habit
   task automatic write(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      // Released lines flip so a stale value is never mistaken for live
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask
   // One-cycle read; data taken in the following cycle only
   task automatic read(input logic [4:0] a, output logic [15:0] d);
      @(posedge clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      addr_o <= ~a;
      #1;
      d = rdata_i;
   endtask
endmodule

// file: testbench/testbench.sv
// Self-checking bench for the codec status and input-control registers
`timescale 1ns/100ps
module testbench;
   // ****************************************************************
   // Signals
   // ****************************************************************
   localparam logic [3:0] REV = 4'h5; // Arbitrary revision value
   localparam logic [15:0] REVW = {12'h000, REV};
   logic clk = 1'b0; // 10 MHz clock
   logic rst = 1'b1; // Reset pin
   logic pin_n = 1'b1; // Power-down pin, low active
   logic role = 1'b1; // Bus role pin, high for slave
   logic empty_a = 1'b0, empty_b = 1'b0; // DAC buffer empty events
   logic lv = 1'b0, rv = 1'b0; // ADC sample strobes
   logic [1:0] ll = 2'h0, rl = 2'h0; // ADC peak codes
   logic [4:0] addr;
   logic [15:0] wdata, rdata, d;
   logic wr, rd, settle, pdf, zf_a, zf_b, lmb, rmb;
   logic [2:0] lss, rss;
   logic [3:0] lig, rig, ens;
   logic [6:0] lhd, rhd;
   int err_count = 0;
   int comparisons = 0;
   int cycles = 0;
   int e;
   always #50 clk = ~clk;
   // ****************************************************************
   // Design and host model
   // ****************************************************************
   csr_regs #(.REVISION(REV), .SETTLE_CYCLES(20)) dut (.clk_i(clk), .rst_i(rst),
      .powerdown_pin_n_i(pin_n), .bus_role_select_i(role), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .dac_a_empty_i(empty_a),
      .dac_b_empty_i(empty_b), .adc_left_valid_i(lv), .adc_left_level_i(ll),
      .adc_right_valid_i(rv), .adc_right_level_i(rl), .clock_settle_o(settle),
      .converter_powerdown_flag_o(pdf), .dac_a_zero_fill_o(zf_a), .dac_b_zero_fill_o(zf_b),
      .left_source_select_o(lss), .right_source_select_o(rss), .left_mic_boost_o(lmb),
      .right_mic_boost_o(rmb), .left_input_gain_o(lig), .right_input_gain_o(rig),
      .left_gain_half_db_o(lhd), .right_gain_half_db_o(rhd), .channel_enables_o(ens));
   csr_host_model host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
      .wr_o(wr), .rd_o(rd));
   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Compare and count
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Read a register and compare
   task automatic rchk(input string name, input logic [4:0] a, input logic [15:0] exp);
      host.read(a, d);
      check(name, d, exp);
   endtask
   // Poll settle (sel 0) or power-down flag (sel 1) with a bound
   task automatic wait_flag(input bit sel, input logic lvl, input int n);
      logic cur;
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         #1;
         cur = sel ? pdf : settle;
         if (cur === lvl) return;
      end
      check("flag_wait", {15'h0000, cur}, {15'h0000, lvl});
   endtask
   // One-cycle event pulse on the DAC or ADC side
   task automatic events(input logic a, input logic b, input logic l, input logic r);
      @(posedge clk);
      empty_a <= a;
      empty_b <= b;
      lv <= l;
      rv <= r;
      @(posedge clk);
      empty_a <= 1'b0;
      empty_b <= 1'b0;
      lv <= 1'b0;
      rv <= 1'b0;
   endtask
   // Verdict and end of run
   task automatic complete_run();
      if (err_count == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         complete_run();
      end
   end
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      #1;
      check("settle_after_reset", {15'h0000, settle}, 16'h0001);
      check("pd_after_reset", {15'h0000, pdf}, 16'h0001);
      host.write(csr_pkg::ADDR_FUNDAMENTAL, 16'h0000); // Ignored while settling
      rchk("status_settling", csr_pkg::ADDR_STATUS, 16'hC000 | REVW);
      wait_flag(1'b0, 1'b0, 100);
      rchk("status_settled", csr_pkg::ADDR_STATUS, 16'h4000 | REVW);
      host.write(csr_pkg::ADDR_INPUT, 16'hFFFF);
      rchk("input_blocked", csr_pkg::ADDR_INPUT, 16'h0000);
      host.write(csr_pkg::ADDR_FUNDAMENTAL, 16'h0000);
      @(posedge clk);
      #1;
      check("pd_leaving", {15'h0000, pdf}, 16'h0001);
      wait_flag(1'b1, 1'b0, 40);
      rchk("status_running", csr_pkg::ADDR_STATUS, REVW);
      host.write(csr_pkg::ADDR_STATUS, 16'hC00F);
      rchk("status_readonly", csr_pkg::ADDR_STATUS, REVW);
      host.write(csr_pkg::ADDR_ENABLES, 16'h000F);
      // Every source code, both boost values, per-channel fields
      for (int s = 0; s < 8; s++) begin
         host.write(csr_pkg::ADDR_INPUT, {3'(s), 1'(s), 1'b0, 3'(s), 3'(7 - s),
            1'(s + 1), 1'b0, 3'(7 - s)});
         rchk("input_rb", csr_pkg::ADDR_INPUT, {3'(s), 1'(s), 1'b0, 3'(s), 3'(7 - s),
            1'(s + 1), 1'b0, 3'(7 - s)});
         check("lss", {13'h0000, lss}, 16'(s));
         check("rss", {13'h0000, rss}, 16'(7 - s));
         e = 40 * (s % 2) + 3 * s;
         check("left_gain", {9'h000, lhd}, 16'(e));
         e = 40 * ((s + 1) % 2) + 3 * (7 - s);
         check("right_gain", {9'h000, rhd}, 16'(e));
         check("boosts", {14'h0000, lmb, rmb}, {14'h0000, 1'(s), 1'(s + 1)});
         check("gains", {8'h00, lig, rig}, {8'h00, 4'(s), 4'(7 - s)});
      end
      // Full gain codes, left with boost
      host.write(csr_pkg::ADDR_INPUT, 16'h1F0F);
      rchk("input_full", csr_pkg::ADDR_INPUT, 16'h1F0F);
      check("left_gain_max", {9'h000, lhd}, 16'h0055);
      check("right_gain_max", {9'h000, rhd}, 16'h002D);
      check("enables", {12'h000, ens}, 16'h000F);
      // Sticky flags keep the largest code and the underrun
      ll <= 2'h2;
      rl <= 2'h3;
      events(1'b1, 1'b0, 1'b1, 1'b1);
      #1;
      check("zero_fill_a", {14'h0000, zf_a, zf_b}, 16'h0002);
      ll <= 2'h1;
      events(1'b0, 1'b0, 1'b1, 1'b0);
      rchk("flags_sticky", csr_pkg::ADDR_FLAGS, 16'h010E);
      rchk("flags_read_clr", csr_pkg::ADDR_FLAGS, 16'h0000);
      events(1'b0, 1'b1, 1'b0, 1'b0);
      host.write(csr_pkg::ADDR_FLAGS, 16'h0000);
      rchk("flags_write_clr", csr_pkg::ADDR_FLAGS, 16'h0000);
      host.write(csr_pkg::ADDR_ENABLES, 16'h0000);
      events(1'b1, 1'b0, 1'b0, 1'b0);
      rchk("flags_disabled", csr_pkg::ADDR_FLAGS, 16'h0000);
      rchk("unmapped", 5'h1D, 16'h0000);
      // Power-down pin: sequence ends in settle, registers cleared
      host.write(csr_pkg::ADDR_ENABLES, 16'h000F);
      host.write(csr_pkg::ADDR_INPUT, 16'h1234);
      events(1'b1, 1'b0, 1'b0, 1'b0);
      pin_n <= 1'b0;
      wait_flag(1'b0, 1'b1, 40);
      rchk("status_pin_low", csr_pkg::ADDR_STATUS, 16'hC000 | REVW);
      rchk("flags_pin_low", csr_pkg::ADDR_FLAGS, 16'h0000);
      rchk("input_pin_low", csr_pkg::ADDR_INPUT, 16'h0000);
      check("ens_pin_low", {12'h000, ens}, 16'h0000);
      // Bus master role: reads refused while clocks settle
      role <= 1'b0;
      @(posedge clk);
      pin_n <= 1'b1;
      rchk("status_master", csr_pkg::ADDR_STATUS, 16'h0000);
      role <= 1'b1;
      wait_flag(1'b0, 1'b0, 100);
      rchk("status_pin_up", csr_pkg::ADDR_STATUS, 16'h4000 | REVW);
      // Second reset in mid-run brings the settle flag back
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1;
      check("settle_reset_again", {15'h0000, settle}, 16'h0001);
      check("pd_reset_again", {15'h0000, pdf}, 16'h0001);
      complete_run();
   end
endmodule
